// ### tx_write_port.sv
// Transmit write enable and port address logic of the multi-port bus.
//
// How it works
// R1 - Packet mode offers packet-level and byte-level transfer.
// R2 - Enable high selects, enable low transfers.
// R3 - During transfer, address only polls space.
// R4 - During transfer, show selected port space.
// R5 - During selection, address polls and picks port.
// R6 - Byte-level: each enabled cycle writes one word.
// R7 - Byte-level: no polling, four direct space outputs.
// R8 - Enable sampled on each bus clock rise.
// R9 - Cell mode: address picks write and poll FIFO.
// R10 - Address all-ones is null, selects no port.
// R11 - Address sampled on each bus clock rise.
// R12 - Controller drives write enable active low.
// R13 - Cell mode: high latches address, low writes.
// R14 - Last selection-phase address becomes transfer port.
`timescale 1ns/100ps
`default_nettype none

`include "tx_port_defines.svh"

module tx_write_port #(
    parameter logic [`ADDR_W-1:0] PORT_BASE  = `PORT_BASE_ADDR,
    parameter int                 FIFO_DEPTH = `FIFO_DEPTH
) (
    // Core clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // Core-side configuration and port status
    input  wire logic                   packet_mode,
    input  wire logic                   byte_level,
    input  wire logic [`PORT_COUNT-1:0] port_space_avail,
    // Core-side word stream
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [`DATA_W-1:0]          out_data,
    output logic [`PORT_IDX_W-1:0]      out_port,
    output logic                        overflow,
    // Transmit bus, on the bus clock
    input  wire logic                   tfclk,
    input  wire logic                   tenb_n,
    input  wire logic [`ADDR_W-1:0]     tadr,
    input  wire logic [`DATA_W-1:0]     tdat,
    output logic                        tca,
    output logic                        polled_packet_space_avail,
    output logic                        selected_port_space_avail,
    output logic [`PORT_COUNT:1]        direct_port_space_avail
);

    localparam int WORD_W = `DATA_W + `PORT_IDX_W;

    tx_port_pkg::link_state_type link;
    tx_port_pkg::link_state_type next_link;
    tx_port_pkg::core_state_type core;
    tx_port_pkg::core_state_type next_core;

    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [WORD_W-1:0]   fifo_out_data;

    // Returns {valid, index} for a bus address; the null address never maps.
    function automatic logic [`PORT_IDX_W:0] decode_port(input logic [`ADDR_W-1:0] addr);
        logic [`ADDR_W-1:0] offset;
        logic               valid;
        offset = addr - PORT_BASE;
        valid  = (addr != `NULL_PORT_ADDR) && (offset < `ADDR_W'(`PORT_COUNT)); // [R10]
        return {valid, offset[`PORT_IDX_W-1:0]};
    endfunction

    // Maps the synchronised mode bits {packet_mode, byte_level} to a mode.
    function automatic tx_port_pkg::mode_type decode_mode(input logic [`MODE_BITS_W-1:0] bits);
        tx_port_pkg::mode_type mode;
        mode = tx_port_pkg::MODE_CELL;
        if (bits == `MODE_BYTE_CODE)
        begin
            mode = tx_port_pkg::MODE_BYTE_LEVEL;
        end
        else if (bits[1])
        begin
            mode = tx_port_pkg::MODE_PACKET_LEVEL;
        end
        return mode;
    endfunction

    // Bus clock domain.

    logic [`PORT_IDX_W:0]  poll;
    tx_port_pkg::mode_type link_mode;
    logic                  poll_space;
    logic                  sel_space;

    always_comb
    begin
        next_link = link;
        poll      = decode_port(tadr); // [R11]
        link_mode = decode_mode(link.mode_sync2); // [R1]
        poll_space = poll[`PORT_IDX_W] && link.space_sync2[poll[`PORT_IDX_W-1:0]];
        sel_space  = link.sel_valid && link.space_sync2[link.sel_index];

        next_link.mode_sync1  = {packet_mode, byte_level};
        next_link.mode_sync2  = link.mode_sync1;
        next_link.space_sync1 = core.space_out;
        next_link.space_sync2 = link.space_sync1;

        // Write enable is active low; high is the selection phase.
        if (tenb_n) // [R8] [R12]
        begin
            // Latching on every deasserted cycle leaves the last one in force.
            next_link.phase     = tx_port_pkg::PHASE_SELECT; // [R2] [R5] [R13]
            next_link.sel_valid = poll[`PORT_IDX_W]; // [R14] [R9]
            next_link.sel_index = poll[`PORT_IDX_W-1:0];
        end
        else
        begin
            // The address only polls here; the selection stands.
            next_link.phase = tx_port_pkg::PHASE_TRANSFER; // [R2] [R3]
            if (link.sel_valid) // [R6] [R13] [R10]
            begin
                next_link.hold_data    = tdat;
                next_link.hold_port    = link.sel_index;
                next_link.write_toggle = !link.write_toggle;
            end
        end

        next_link.tca      = 1'b0;
        next_link.polled   = 1'b0;
        next_link.selected = 1'b0;
        next_link.direct   = '0;
        case (link_mode)
            tx_port_pkg::MODE_CELL:
            begin
                next_link.tca = poll_space; // [R9]
            end
            tx_port_pkg::MODE_PACKET_LEVEL:
            begin
                next_link.polled = poll_space; // [R3] [R5]
                if (!tenb_n)
                begin
                    next_link.selected = sel_space; // [R4]
                end
            end
            tx_port_pkg::MODE_BYTE_LEVEL:
            begin
                next_link.direct = link.space_sync2; // [R7]
            end
            default:
            begin
                next_link.tca = 1'b0;
            end
        endcase
    end

    always_ff @(posedge tfclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link.mode_sync1   <= '0;
            link.mode_sync2   <= '0;
            link.space_sync1  <= '0;
            link.space_sync2  <= '0;
            link.phase        <= tx_port_pkg::PHASE_SELECT;
            link.sel_valid    <= 1'b0;
            link.sel_index    <= '0;
            link.hold_data    <= '0;
            link.hold_port    <= '0;
            link.write_toggle <= 1'b0;
            link.tca          <= 1'b0;
            link.polled       <= 1'b0;
            link.selected     <= 1'b0;
            link.direct       <= '0;
        end
        else
        begin
            link <= next_link;
        end
    end

    assign tca                       = link.tca;
    assign polled_packet_space_avail = link.polled;
    assign selected_port_space_avail = link.selected;
    assign direct_port_space_avail   = link.direct;

    // Core clock domain.

    always_comb
    begin
        next_core = core;
        next_core.tog_sync1 = link.write_toggle;
        next_core.tog_sync2 = core.tog_sync1;
        next_core.tog_seen  = core.tog_sync2;
        // A full FIFO withdraws all space so the controller holds off.
        next_core.space_out = port_space_avail & {`PORT_COUNT{fifo_in_ready}};
        next_core.push_valid = 1'b0;
        next_core.overflow   = 1'b0;
        // Hold registers stay put for a full bus cycle after the toggle,
        // which outlasts the three core cycles the toggle needs to arrive.
        if (core.tog_sync2 != core.tog_seen)
        begin
            next_core.push_valid = 1'b1;
            next_core.push_data  = link.hold_data;
            next_core.push_port  = link.hold_port;
        end
        if (core.push_valid && !fifo_in_ready)
        begin
            next_core.overflow = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core.tog_sync1  <= 1'b0;
            core.tog_sync2  <= 1'b0;
            core.tog_seen   <= 1'b0;
            core.space_out  <= '0;
            core.push_valid <= 1'b0;
            core.push_data  <= '0;
            core.push_port  <= '0;
            core.overflow   <= 1'b0;
        end
        else
        begin
            core <= next_core;
        end
    end

    tx_word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (core.push_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({core.push_port, core.push_data}),
        .out_valid (fifo_out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out_data)
    );

    assign out_valid = fifo_out_valid;
    assign out_data  = fifo_out_data[`DATA_W-1:0];
    assign out_port  = fifo_out_data[WORD_W-1:`DATA_W];
    assign overflow  = core.overflow;

endmodule // tx_write_port

`default_nettype wire

// ### tx_port_defines.svh
// Constants for the transmit multi-port write interface.
`ifndef TX_PORT_DEFINES_SVH
`define TX_PORT_DEFINES_SVH

`define ADDR_W          5
`define DATA_W          16
`define PORT_COUNT      4
`define PORT_IDX_W      2
`define NULL_PORT_ADDR  5'h1F
`define PORT_BASE_ADDR  5'h00
`define FIFO_DEPTH      16
`define MODE_BITS_W     2
`define MODE_CELL_CODE  2'h0
`define MODE_BYTE_CODE  2'h3

`endif

// ### tx_port_pkg.sv
// Types shared by the transmit multi-port write interface.
`include "tx_port_defines.svh"

package tx_port_pkg;

    typedef enum logic [1:0] {
        MODE_CELL,
        MODE_PACKET_LEVEL,
        MODE_BYTE_LEVEL
    } mode_type;

    typedef enum logic {
        PHASE_SELECT,
        PHASE_TRANSFER
    } phase_type;

    // Logic that faces the bus, clocked by the bus clock.
    typedef struct packed {
        logic [`MODE_BITS_W-1:0] mode_sync1;
        logic [`MODE_BITS_W-1:0] mode_sync2;
        logic [`PORT_COUNT-1:0]  space_sync1;
        logic [`PORT_COUNT-1:0]  space_sync2;
        phase_type               phase;
        logic                    sel_valid;
        logic [`PORT_IDX_W-1:0]  sel_index;
        logic [`DATA_W-1:0]      hold_data;
        logic [`PORT_IDX_W-1:0]  hold_port;
        logic                    write_toggle;
        logic                    tca;
        logic                    polled;
        logic                    selected;
        logic [`PORT_COUNT-1:0]  direct;
    } link_state_type;

    // Logic on the core clock.
    typedef struct packed {
        logic                    tog_sync1;
        logic                    tog_sync2;
        logic                    tog_seen;
        logic [`PORT_COUNT-1:0]  space_out;
        logic                    push_valid;
        logic [`DATA_W-1:0]      push_data;
        logic [`PORT_IDX_W-1:0]  push_port;
        logic                    overflow;
    } core_state_type;

endpackage

// ### tx_word_fifo.sv
// Synchronous word FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none

module tx_word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge mclk)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                count <= count + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // tx_word_fifo

`default_nettype wire

// ### tx_write_port_assertions.sv
// Concurrent checks on the ports of the transmit write port.
`timescale 1ns/100ps
`default_nettype none
`include "tx_port_defines.svh"
module tx_write_port_checker (
    // Core side
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire logic                   packet_mode,
    input wire logic                   byte_level,
    input wire logic [`PORT_COUNT-1:0] port_space_avail,
    input wire logic                   out_valid,
    input wire logic                   out_ready,
    input wire logic [`DATA_W-1:0]     out_data,
    input wire logic [`PORT_IDX_W-1:0] out_port,
    input wire logic                   overflow,
    // Bus side
    input wire logic                   tfclk,
    input wire logic                   tenb_n,
    input wire logic [`ADDR_W-1:0]     tadr,
    input wire logic                   tca,
    input wire logic                   polled_packet_space_avail,
    input wire logic                   selected_port_space_avail,
    input wire logic [`PORT_COUNT:1]   direct_port_space_avail
);
    AST_CELL_QUIET: assert property (@(posedge tfclk) disable iff (!rst_n)
        (!packet_mode)[*4] |=> !polled_packet_space_avail && direct_port_space_avail == 4'h0)
        else $error("packet outputs active in cell mode");
    AST_PKT_NO_TCA: assert property (@(posedge tfclk) disable iff (!rst_n)
        packet_mode[*4] |=> !tca) else $error("cell poll active in packet mode");
    AST_BYTE_NO_POLL: assert property (@(posedge tfclk) disable iff (!rst_n)
        (packet_mode && byte_level)[*4] |=> !polled_packet_space_avail)
        else $error("polling active in byte-level transfer");
    AST_NULL_POLL: assert property (@(posedge tfclk) disable iff (!rst_n)
        (!packet_mode)[*4] ##0 (tadr == `NULL_PORT_ADDR) |=> !tca)
        else $error("null address reported space");
    AST_SPACE_ZERO: assert property (@(posedge tfclk) disable iff (!rst_n)
        (!packet_mode && port_space_avail == 4'h0)[*4] |=> !tca)
        else $error("space shown with no port space");
    AST_SELECTED: assert property (@(posedge tfclk) disable iff (!rst_n)
        selected_port_space_avail |-> !$past(tenb_n))
        else $error("selected status shown outside transfer phase");
    AST_OUT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_port))
        else $error("stalled head word changed");
    AST_OVERFLOW: assert property (@(posedge mclk) disable iff (!rst_n)
        overflow |=> !overflow) else $error("overflow longer than one cycle");
    COV_TCA: cover property (@(posedge tfclk) disable iff (!rst_n) tca);
    COV_SEL: cover property (@(posedge tfclk) disable iff (!rst_n) selected_port_space_avail);
    COV_OVF: cover property (@(posedge mclk) disable iff (!rst_n) overflow);
endmodule // tx_write_port_checker
bind tx_write_port tx_write_port_checker u_tx_write_port_checker (.mclk, .rst_n, .packet_mode,
    .byte_level, .port_space_avail, .out_valid, .out_ready, .out_data, .out_port, .overflow,
    .tfclk, .tenb_n, .tadr, .tca, .polled_packet_space_avail, .selected_port_space_avail,
    .direct_port_space_avail);
`default_nettype wire

// ### link_ctrl_model.sv
// Upstream link controller that drives the transmit bus.
`timescale 1ns/100ps
`default_nettype none
`include "tx_port_defines.svh"
module link_ctrl_model (
    // Bus
    input wire logic                tfclk,
    output logic                    tenb_n,
    output logic [`ADDR_W-1:0]      tadr,
    output logic [`DATA_W-1:0]      tdat
);
    initial
    begin
        tenb_n = 1'b1;
        tadr   = `NULL_PORT_ADDR;
        tdat   = 16'h0000;
    end
    // One bus cycle; returns just after the edge that samples it.
    task automatic bus_cycle(input logic en_n, input logic [4:0] addr, input logic [15:0] data);
        @(negedge tfclk);
        tenb_n = en_n;
        tadr   = addr;
        // An unsampled word keeps moving so a stale value cannot pass.
        tdat   = en_n ? ~tdat : data;
        @(posedge tfclk);
        #1;
    endtask
endmodule // link_ctrl_model
`default_nettype wire

// ### tb_multi_phy_tx_write_port.sv
// Self-checking bench for the transmit write port.
`timescale 1ns/100ps
`default_nettype none
`include "tx_port_defines.svh"
module tb_multi_phy_tx_write_port;
    logic        mclk = 1'b0;
    logic        tfclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        packet_mode = 1'b0;
    logic        byte_level = 1'b0;
    logic [3:0]  space = 4'h0;
    logic        out_valid, out_ready = 1'b0, overflow, tca, polled, selected, tenb_n;
    logic [15:0] out_data, tdat;
    logic [1:0]  out_port;
    logic [4:0]  tadr;
    logic [4:1]  direct;
    int          err_count = 0;
    int          n_compared = 0;
    int          ovf_seen = 0;
    always #2 mclk = ~mclk;
    always #15 tfclk = ~tfclk;
    // Overflow is counted half a cycle after the edge that launches it.
    always @(negedge mclk) if (overflow === 1'b1) ovf_seen++;
    tx_write_port u_tx_write_port (.mclk, .rst_n, .packet_mode, .byte_level,
        .port_space_avail(space), .out_valid, .out_ready, .out_data, .out_port, .overflow,
        .tfclk, .tenb_n, .tadr, .tdat, .tca, .polled_packet_space_avail(polled),
        .selected_port_space_avail(selected), .direct_port_space_avail(direct));
    link_ctrl_model u_link_ctrl_model (.tfclk, .tenb_n, .tadr, .tdat);
    task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic en_n, input logic [4:0] a, input logic [15:0] d);
        u_link_ctrl_model.bus_cycle(en_n, a, d);
    endtask
    task automatic set_cfg(input logic pm, input logic bl, input logic [3:0] sp);
        @(negedge mclk);
        packet_mode = pm;
        byte_level  = bl;
        space       = sp;
        repeat (6) @(posedge tfclk);
        #1;
    endtask
    task automatic expect_word(input logic [15:0] d, input logic [1:0] p);
        int i;
        // Bus tasks can return on a core clock rise, so look only at falling edges.
        @(negedge mclk);
        for (i = 0; i < 60 && out_valid !== 1'b1; i++) @(negedge mclk);
        if (i == 60)
        begin
            err_count++;
            final_report();
        end
        else
        begin
            check_value(out_data, d);
            check_value({14'h0, out_port}, {14'h0, p});
            out_ready = 1'b1;
            @(negedge mclk);
            out_ready = 1'b0;
        end
    endtask
    task automatic t_cell;
        set_cfg(1'b0, 1'b0, 4'h0);
        bus(1'b1, 5'h00, 16'h0);
        check_value({15'h0, tca}, 16'h0000);
        set_cfg(1'b0, 1'b0, 4'h5);
        for (int a = 0; a < 4; a++)
        begin
            bus(1'b1, 5'(a), 16'h0);
            check_value({15'h0, tca}, {15'h0, space[a]});
        end
        bus(1'b1, 5'h1F, 16'h0);
        check_value({15'h0, tca}, 16'h0000);
        bus(1'b1, 5'h02, 16'h0);
        bus(1'b0, 5'h00, 16'hC0DE);
        bus(1'b1, 5'h1F, 16'h0);
        expect_word(16'hC0DE, 2'h2);
    endtask
    task automatic t_packet;
        set_cfg(1'b1, 1'b0, 4'h6);
        bus(1'b1, 5'h01, 16'h0);
        check_value({15'h0, polled}, 16'h0001);
        bus(1'b1, 5'h00, 16'h0);
        check_value({15'h0, polled}, 16'h0000);
        bus(1'b1, 5'h02, 16'h0);
        bus(1'b0, 5'h00, 16'hAAA1);
        check_value({14'h0, polled, selected}, 16'h0001);
        bus(1'b0, 5'h01, 16'hAAA2);
        check_value({14'h0, polled, selected}, 16'h0003);
        bus(1'b1, 5'h1F, 16'h0);
        check_value({15'h0, selected}, 16'h0000);
        bus(1'b0, 5'h01, 16'hDEAD);
        bus(1'b1, 5'h1F, 16'h0);
        expect_word(16'hAAA1, 2'h2);
        expect_word(16'hAAA2, 2'h2);
        repeat (30) @(negedge mclk);
        check_value({15'h0, out_valid}, 16'h0000);
    endtask
    task automatic t_byte;
        set_cfg(1'b1, 1'b1, 4'h9);
        check_value({11'h0, direct, polled}, 16'h0012);
        bus(1'b1, 5'h03, 16'h0);
        bus(1'b0, 5'h00, 16'h0011);
        bus(1'b1, 5'h03, 16'h0);
        bus(1'b0, 5'h00, 16'h0022);
        bus(1'b1, 5'h03, 16'h0);
        expect_word(16'h0011, 2'h3);
        expect_word(16'h0022, 2'h3);
        repeat (30) @(negedge mclk);
        check_value({15'h0, out_valid}, 16'h0000);
    endtask
    task automatic t_full;
        set_cfg(1'b1, 1'b1, 4'hF);
        bus(1'b1, 5'h01, 16'h0);
        for (int i = 0; i < 17; i++) bus(1'b0, 5'h00, 16'h0100 + 16'(i));
        bus(1'b1, 5'h1F, 16'h0);
        repeat (4) @(posedge tfclk);
        #1;
        check_value({12'h0, direct}, 16'h0000);
        check_value(16'(ovf_seen), 16'h0001);
        for (int i = 0; i < 16; i++) expect_word(16'h0100 + 16'(i), 2'h1);
        repeat (6) @(posedge tfclk);
        #1;
        check_value({12'h0, direct, out_valid}, 16'h001E);
    endtask
    initial
    begin
        repeat (6) @(negedge tfclk);
        @(negedge mclk);
        rst_n = 1'b1;
        t_cell();
        t_packet();
        t_byte();
        t_full();
        final_report();
    end
endmodule // tb_multi_phy_tx_write_port
`default_nettype wire
